// >>> logic/ddrbp_pkg.sv
// ****************************************************************
// shared constants and carriers for the burst protocol block
// ****************************************************************
package ddrbp_pkg;
    // burst mode field of mode_register_zero
    localparam logic [1:0] BM_FULL8 = 2'h0;
    localparam logic [1:0] BM_CHOP4 = 2'h2;
    localparam logic [1:0] BM_PERCMD = 2'h1;
    // additive latency selections
    localparam logic [1:0] AL_ZERO = 2'h0;
    localparam logic [1:0] AL_CL_M1 = 2'h1;
    localparam logic [1:0] AL_CL_M2 = 2'h2;
    localparam logic [4:0] AL_NONE = 5'h00;
    localparam logic [4:0] AL_ONE = 5'h01;
    localparam logic [4:0] AL_TWO = 5'h02;
    // widths, depths and positions
    localparam int ADDR_W = 13;
    localparam int COL_W = 10;
    localparam int BL_SEL_BIT = 12;
    localparam int DQ_W = 8;
    localparam int TICK_W = 8;
    localparam int LAT_W = 5;
    localparam int QDEPTH = 8;
    localparam int QIDX_W = 3;
    localparam int MEM_DEPTH = 64;
    localparam int MEM_IDX_W = 6;
    localparam int SYNC_W = 27;
    localparam int SY_CK = 26;
    localparam int SY_DQS = 25;
    localparam int SY_DQ_LO = 17;
    // beats remaining after the first one, column step and full counts
    localparam logic [2:0] FULL8_LEFT = 3'h7;
    localparam logic [2:0] CHOP4_LEFT = 3'h3;
    localparam logic [2:0] BEAT_STEP = 3'h1;
    localparam logic [3:0] QCNT_FULL = 4'h8;
    localparam logic [1:0] BUF_FULL = 2'h2;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [ADDR_W-1:0] addr;
    } ddrbp_cmd_t;

    typedef struct packed {
        logic wr;
        logic chop;
        logic [COL_W-1:0] col;
        logic [TICK_W-1:0] due;
    } ddrbp_qent_t;

    typedef struct packed {
        logic [COL_W-1:0] col;
        logic [DQ_W-1:0] data;
    } ddrbp_beat_t;
endpackage

// >>> logic/ddrbp_buf2.sv
`timescale 1ns/10ps
// ****************************************************************
// two-entry buffer for captured write beats
// ****************************************************************
module ddrbp_buf2 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input ddrbp_pkg::ddrbp_beat_t in_data,
    output logic out_valid,
    input wire logic out_ready,
    output ddrbp_pkg::ddrbp_beat_t out_data
);
    ddrbp_pkg::ddrbp_beat_t slot_r [2];
    logic wr_ptr_r;
    logic rd_ptr_r;
    logic [1:0] cnt_r;
    logic do_push;
    logic do_pop;

    // full and empty straight from the occupancy count
    assign in_ready = (cnt_r != ddrbp_pkg::BUF_FULL);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data = slot_r[rd_ptr_r];
    assign do_push = in_valid && in_ready;
    assign do_pop = out_valid && out_ready;

    // storage and pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_r[0] <= '0;
            slot_r[1] <= '0;
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (do_push) begin
                slot_r[wr_ptr_r] <= in_data;
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (do_pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            cnt_r <= cnt_r + {1'b0, do_push} - {1'b0, do_pop};
        end
    end
endmodule // ddrbp_buf2

// >>> logic/ddrbp_core.sv
`timescale 1ns/10ps
// Behaviour
// - burst field 00 fixed eight beats, 10 fixed four-beat chop, 01 per command
// - per-command mode: address bit twelve low chops to four, high gives eight
// - address bit twelve never enters the column address
// - write: select, column strobe, write enable low, row strobe high at rise
// - starting column comes from address sampled with the write
// - write latency equals additive plus write column latency
// - first write beat on first strobe rise after preamble, then every edge
// - beats beyond the burst length are ignored
// - reads four clocks after an eight-beat read give gapless back-to-back bursts
// - reads further apart leave a matching idle gap
// - length choice works with or without auto precharge
// - additive latency of column latency minus one adds to both latencies
// - read: select and column strobe low, row strobe and write enable high
// - read latency equals additive plus column latency
// - read strobe low one clock before first beat, beat on first rise
module ddrbp_core (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] mode_burst,
    input wire logic [3:0] cas_lat,
    input wire logic [3:0] cas_wr_lat,
    input wire logic [1:0] add_lat_sel,
    input wire logic ck,
    input ddrbp_pkg::ddrbp_cmd_t pin_cmd,
    input wire logic [ddrbp_pkg::DQ_W-1:0] dq_i,
    output logic [ddrbp_pkg::DQ_W-1:0] dq_o,
    output logic dq_oe,
    input wire logic dqs_i,
    output logic dqs_o,
    output logic dqs_oe,
    output logic wbuf_ready,
    output logic wbeat_valid,
    input wire logic wbeat_ready,
    output ddrbp_pkg::ddrbp_beat_t wbeat
);
    typedef enum {RD_IDLE, RD_PRE, RD_DATA, RD_POST} ddrbp_rd_t;
    typedef enum {CAP_IDLE, CAP_WAIT, CAP_RUN} ddrbp_cap_t;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // chop decision; the auto precharge bit plays no part in it
    function automatic logic chop_of(input logic [1:0] mode, input logic sel);
        chop_of = (mode == ddrbp_pkg::BM_CHOP4) || ((mode == ddrbp_pkg::BM_PERCMD) && !sel);
    endfunction

    // beats remaining once the first has moved
    function automatic logic [2:0] left_of(input logic chop);
        left_of = chop ? ddrbp_pkg::CHOP4_LEFT : ddrbp_pkg::FULL8_LEFT;
    endfunction

    // sequential order wraps inside the eight-column block
    function automatic logic [9:0] col_step(input logic [9:0] col);
        col_step = {col[9:3], col[2:0] + ddrbp_pkg::BEAT_STEP};
    endfunction

    // ****************************************************************
    // pin synchroniser
    // ****************************************************************
    logic [ddrbp_pkg::SYNC_W-1:0] s1_r;
    logic [ddrbp_pkg::SYNC_W-1:0] s2_r;
    logic [ddrbp_pkg::SYNC_W-1:0] s3_r;
    logic ck_acc_r;
    logic dqs_acc_r;
    logic ck_chg;
    logic ck_rise;
    logic dqs_chg;
    logic dqs_rise;
    ddrbp_pkg::ddrbp_cmd_t cmd;
    logic [ddrbp_pkg::DQ_W-1:0] dq_s;

    // every pin rides the same three stages, so data stays aligned to its edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= {ck, dqs_i, dq_i, pin_cmd};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // an edge counts once stages two and three agree on a new level
    assign ck_chg = (s2_r[ddrbp_pkg::SY_CK] == s3_r[ddrbp_pkg::SY_CK])
        && (s3_r[ddrbp_pkg::SY_CK] != ck_acc_r);
    assign ck_rise = ck_chg && s3_r[ddrbp_pkg::SY_CK];
    assign dqs_chg = (s2_r[ddrbp_pkg::SY_DQS] == s3_r[ddrbp_pkg::SY_DQS])
        && (s3_r[ddrbp_pkg::SY_DQS] != dqs_acc_r);
    assign dqs_rise = dqs_chg && s3_r[ddrbp_pkg::SY_DQS];
    assign cmd = s3_r[ddrbp_pkg::SY_DQ_LO-1:0];
    assign dq_s = s3_r[ddrbp_pkg::SY_DQS-1:ddrbp_pkg::SY_DQ_LO];

    // accepted levels
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ck_acc_r <= 1'b0;
            dqs_acc_r <= 1'b0;
        end else begin
            ck_acc_r <= ck_chg ? s3_r[ddrbp_pkg::SY_CK] : ck_acc_r;
            dqs_acc_r <= dqs_chg ? s3_r[ddrbp_pkg::SY_DQS] : dqs_acc_r;
        end
    end

    // ****************************************************************
    // command decode and latency
    // ****************************************************************
    logic [ddrbp_pkg::TICK_W-1:0] tick_r;
    logic [4:0] al;
    logic [4:0] rl;
    logic [4:0] wl;
    logic col_cmd;
    logic is_wr;
    ddrbp_pkg::ddrbp_qent_t new_ent;

    // posted command: additive latency taken from the column latency
    assign al = (add_lat_sel == ddrbp_pkg::AL_CL_M1) ? {1'b0, cas_lat} - ddrbp_pkg::AL_ONE :
        (add_lat_sel == ddrbp_pkg::AL_CL_M2) ? {1'b0, cas_lat} - ddrbp_pkg::AL_TWO :
        ddrbp_pkg::AL_NONE;
    assign rl = al + {1'b0, cas_lat};
    assign wl = al + {1'b0, cas_wr_lat};
    // read and write share everything but the write enable level
    assign col_cmd = !cmd.cs_n && cmd.ras_n && !cmd.cas_n;
    assign is_wr = !cmd.we_n;
    assign new_ent.wr = is_wr;
    assign new_ent.chop = chop_of(mode_burst, cmd.addr[ddrbp_pkg::BL_SEL_BIT]);
    assign new_ent.col = cmd.addr[ddrbp_pkg::COL_W-1:0];
    assign new_ent.due = tick_r + {3'h0, is_wr ? wl : rl};

    // link clock count, one step per rising edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_r <= '0;
        end else if (ck_rise) begin
            tick_r <= tick_r + 8'h01;
        end
    end

    // ****************************************************************
    // pending column commands, oldest first
    // ****************************************************************
    ddrbp_pkg::ddrbp_qent_t q_r [ddrbp_pkg::QDEPTH];
    logic [ddrbp_pkg::QIDX_W-1:0] q_head_r;
    logic [ddrbp_pkg::QIDX_W-1:0] q_tail_r;
    logic [3:0] q_cnt_r;
    ddrbp_pkg::ddrbp_qent_t head;
    logic q_push;
    logic q_pop;
    logic hd_now;
    logic hd_soon;
    logic rd_start;
    logic rd_pre;
    logic wr_arm;

    // deep enough for the longest latency at four-clock spacing
    assign q_push = ck_rise && col_cmd && (q_cnt_r != ddrbp_pkg::QCNT_FULL);
    assign head = q_r[q_head_r];
    assign hd_now = (q_cnt_r != 4'h0) && (head.due == tick_r);
    assign hd_soon = (q_cnt_r != 4'h0) && (head.due == tick_r + 8'h01);
    assign rd_start = ck_rise && hd_now && !head.wr;
    assign rd_pre = ck_rise && hd_soon && !head.wr;
    // writes arm in the preamble clock and wait for the first strobe rise
    assign wr_arm = ck_rise && hd_soon && head.wr;
    assign q_pop = rd_start || wr_arm;

    // queue storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < ddrbp_pkg::QDEPTH; i++) begin
                q_r[i] <= '0;
            end
            q_head_r <= '0;
            q_tail_r <= '0;
            q_cnt_r <= 4'h0;
        end else begin
            if (q_push) begin
                q_r[q_tail_r] <= new_ent;
                q_tail_r <= q_tail_r + 3'h1;
            end
            if (q_pop) begin
                q_head_r <= q_head_r + 3'h1;
            end
            q_cnt_r <= q_cnt_r + {3'h0, q_push} - {3'h0, q_pop};
        end
    end

    // ****************************************************************
    // array and read burst driver
    // ****************************************************************
    logic [ddrbp_pkg::DQ_W-1:0] mem_r [ddrbp_pkg::MEM_DEPTH];
    ddrbp_rd_t rd_st_r;
    logic [ddrbp_pkg::COL_W-1:0] rd_col_r;
    logic [2:0] rd_left_r;
    logic wr_mem;

    assign wr_mem = wbeat_valid && wbeat_ready;

    // array written only as the buffer drains
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < ddrbp_pkg::MEM_DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else if (wr_mem) begin
            mem_r[wbeat.col[ddrbp_pkg::MEM_IDX_W-1:0]] <= wbeat.data;
        end
    end

    // one beat per link edge; a start at the closing rise chains bursts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_st_r <= RD_IDLE;
            rd_col_r <= '0;
            rd_left_r <= 3'h0;
            dq_o <= '0;
            dq_oe <= 1'b0;
            dqs_o <= 1'b0;
            dqs_oe <= 1'b0;
        end else if (rd_start) begin
            rd_st_r <= RD_DATA;
            rd_col_r <= col_step(head.col);
            rd_left_r <= left_of(head.chop);
            dq_o <= mem_r[head.col[ddrbp_pkg::MEM_IDX_W-1:0]];
            dq_oe <= 1'b1;
            dqs_o <= 1'b1;
            dqs_oe <= 1'b1;
        end else if (ck_chg) begin
            case (rd_st_r)
                RD_DATA: begin
                    if (rd_left_r != 3'h0) begin
                        dq_o <= mem_r[rd_col_r[ddrbp_pkg::MEM_IDX_W-1:0]];
                        rd_col_r <= col_step(rd_col_r);
                        rd_left_r <= rd_left_r - 3'h1;
                        dqs_o <= ~dqs_o;
                    end else if (ck_rise) begin
                        // a read due at the next rise keeps the strobe low through the gap
                        rd_st_r <= rd_pre ? RD_PRE : RD_POST;
                        dq_oe <= 1'b0;
                        dqs_o <= 1'b0;
                    end
                end
                RD_PRE: begin
                    dqs_o <= 1'b0;
                end
                RD_POST: begin
                    if (rd_pre) begin
                        rd_st_r <= RD_PRE;
                    end else begin
                        rd_st_r <= RD_IDLE;
                        dqs_oe <= 1'b0;
                    end
                end
                RD_IDLE: begin
                    if (rd_pre) begin
                        rd_st_r <= RD_PRE;
                        dqs_o <= 1'b0;
                        dqs_oe <= 1'b1;
                    end
                end
                default: begin
                    rd_st_r <= RD_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // write beat capture
    // ****************************************************************
    ddrbp_cap_t cap_st_r;
    logic [ddrbp_pkg::COL_W-1:0] cap_col_r;
    logic [2:0] cap_left_r;
    logic pend_v_r;
    ddrbp_pkg::ddrbp_qent_t pend_r;
    logic cap_beat;
    logic cap_last;
    ddrbp_pkg::ddrbp_beat_t push_beat;

    // first beat on the first strobe rise, then both edges
    assign cap_beat = ((cap_st_r == CAP_WAIT) && dqs_rise)
        || ((cap_st_r == CAP_RUN) && dqs_chg);
    assign cap_last = cap_beat && (cap_left_r == 3'h0);
    assign push_beat.col = cap_col_r;
    assign push_beat.data = dq_s;

    // a write armed while another is landing is held until that one ends
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_st_r <= CAP_IDLE;
            cap_col_r <= '0;
            cap_left_r <= 3'h0;
            pend_v_r <= 1'b0;
            pend_r <= '0;
        end else begin
            if (cap_beat) begin
                cap_st_r <= CAP_RUN;
                cap_col_r <= col_step(cap_col_r);
                cap_left_r <= cap_left_r - 3'h1;
            end
            if (cap_last && pend_v_r) begin
                cap_st_r <= CAP_WAIT;
                cap_col_r <= pend_r.col;
                cap_left_r <= left_of(pend_r.chop);
                pend_v_r <= wr_arm;
                pend_r <= head;
            end else if (wr_arm && (cap_last || cap_st_r == CAP_IDLE)) begin
                cap_st_r <= CAP_WAIT;
                cap_col_r <= head.col;
                cap_left_r <= left_of(head.chop);
            end else if (cap_last) begin
                cap_st_r <= CAP_IDLE;
            end else if (wr_arm) begin
                pend_v_r <= 1'b1;
                pend_r <= head;
            end
        end
    end

    // a stalled drain fills the buffer; wbuf_ready low means beats drop
    ddrbp_buf2 u_buf (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(cap_beat),
        .in_ready(wbuf_ready),
        .in_data(push_beat),
        .out_valid(wbeat_valid),
        .out_ready(wbeat_ready),
        .out_data(wbeat)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_mode_full8: assert property (q_push && mode_burst == ddrbp_pkg::BM_FULL8 |-> !new_ent.chop)
        else $error("fixed eight-beat mode chopped a burst");
    a_percmd_sel: assert property (q_push && mode_burst == ddrbp_pkg::BM_PERCMD
        |-> new_ent.chop == !cmd.addr[ddrbp_pkg::BL_SEL_BIT])
        else $error("per-command length not taken from bit twelve");
    a_col_clean: assert property (q_push |=> q_r[$past(q_tail_r)].col == $past(cmd.addr[9:0]))
        else $error("queued column differs from sampled column");
    a_al_posted: assert property (add_lat_sel == ddrbp_pkg::AL_CL_M1
        |-> rl == {cas_lat, 1'b0} - 5'h01 && wl == {1'b0, cas_lat} + {1'b0, cas_wr_lat} - 5'h01)
        else $error("posted latency wrong");
    a_rd_preamble: assert property ($rose(dq_oe) |-> dqs_o && $past(dqs_oe) && !$past(dqs_o))
        else $error("first read beat without low preamble");
    a_bus_idle: assert property (rd_st_r == RD_IDLE |-> !dq_oe && !dqs_oe)
        else $error("pins driven outside a read burst");
    a_beat_ignored: assert property (cap_st_r != CAP_RUN && !dqs_rise |-> !cap_beat)
        else $error("write beat taken outside a burst");
    a_chain_gapless: assert property (rd_start && rd_st_r == RD_DATA |=> dq_oe && dqs_o && dqs_oe)
        else $error("back-to-back reads left a gap");
endmodule // ddrbp_core

// >>> verif/ddrbp_ctrl_model.sv
`timescale 1ns/10ps
// ****
// controller model: link clock, commands, write strobe
// ****
module ddrbp_ctrl_model (
    output logic ck,
    output ddrbp_pkg::ddrbp_cmd_t pin_cmd,
    output logic [7:0] dq_c,
    output logic dq_en,
    output logic dqs_c,
    output logic dqs_en
);
    int act;
    // link clock runs free, phase unrelated to clk
    initial begin
        ck = 1'b0;
        #213;
        forever #200 ck = ~ck;
    end
    // idle pins at time zero
    initial begin
        pin_cmd = '1;
        dq_c = 8'h00;
        dq_en = 1'b0;
        dqs_c = 1'b0;
        dqs_en = 1'b0;
        act = 0;
    end
    // byte tied to its column so every beat checks itself
    function automatic logic [7:0] dat(input logic [9:0] c);
        return {2'h2, c[5:0]};
    endfunction
    // command held over one ck rise; caller sits on a ck fall
    task automatic issue(input logic wr, input logic [12:0] a);
        pin_cmd <= '{1'b0, 1'b1, 1'b0, ~wr, a};
        @(negedge ck);
        pin_cmd <= '1;
    endtask
    // one write burst; overlapping bursts share the strobe without a gap
    task automatic wr_data(input int wl, input logic [9:0] col, input int n);
        #((wl - 1) * 400 - 200);
        if (act == 0) begin
            dqs_c <= 1'b0;
            dqs_en <= 1'b1;
        end
        act++;
        #300;
        for (int k = 0; k < n; k++) begin
            dq_c <= (k < 8) ? dat({col[9:3], col[2:0] + k[2:0]}) : 8'h5a;
            dq_en <= 1'b1;
            #100;
            dqs_c <= ~k[0];
            #100;
        end
        #100;
        act--;
        // released pins show the inverse of their last level
        if (act == 0) begin
            dq_c <= ~dq_c;
            dq_en <= 1'b0;
            dqs_c <= 1'b1;
            dqs_en <= 1'b0;
        end
    endtask
endmodule // ddrbp_ctrl_model

// >>> verif/tb_top.sv
`timescale 1ns/10ps
// ****
// bench: controller model against the burst core
// ****
module tb_top;
    logic clk;
    logic rst_n;
    logic [1:0] mode_burst;
    logic [3:0] cas_lat;
    logic [3:0] cas_wr_lat;
    logic [1:0] add_lat_sel;
    logic ck;
    ddrbp_pkg::ddrbp_cmd_t pin_cmd;
    logic [7:0] dq_i;
    logic [7:0] dq_o;
    logic [7:0] dq_c;
    logic dq_oe, dq_en, dqs_i, dqs_o, dqs_oe, dqs_c, dqs_en;
    logic wbuf_ready, wbeat_valid, wbeat_ready;
    ddrbp_pkg::ddrbp_beat_t wbeat;
    ddrbp_pkg::ddrbp_beat_t seen_q[$];
    ddrbp_pkg::ddrbp_beat_t exp_q[$];
    logic [63:0] wr_mask;
    int err_total;
    int tests_run;
    // shared pins: a clash of drivers shows as unknown
    assign dq_i = dq_oe ? (dq_en ? 'x : dq_o) : dq_c;
    assign dqs_i = dqs_oe ? (dqs_en ? 1'bx : dqs_o) : dqs_c;
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    ddrbp_core i_ddrbp_core (.clk(clk), .rst_n(rst_n), .mode_burst(mode_burst),
        .cas_lat(cas_lat), .cas_wr_lat(cas_wr_lat), .add_lat_sel(add_lat_sel), .ck(ck),
        .pin_cmd(pin_cmd), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_i(dqs_i),
        .dqs_o(dqs_o), .dqs_oe(dqs_oe), .wbuf_ready(wbuf_ready), .wbeat_valid(wbeat_valid),
        .wbeat_ready(wbeat_ready), .wbeat(wbeat));
    ddrbp_ctrl_model u_ctrl (.ck(ck), .pin_cmd(pin_cmd), .dq_c(dq_c), .dq_en(dq_en),
        .dqs_c(dqs_c), .dqs_en(dqs_en));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // taken beats sampled mid-cycle, away from the handshake edge
    always @(negedge clk) begin
        if (wbeat_valid === 1'b1 && wbeat_ready === 1'b1)
            seen_q.push_back(wbeat);
        if ((dq_oe & dq_en) === 1'b1 || (dqs_oe & dqs_en) === 1'b1)
            chk(1'b1, 1'b0);
    end
    // next command s ck after the last one
    task automatic gap(input int s);
        repeat (s - 1) @(negedge ck);
    endtask
    task automatic cfg(input logic [1:0] m, input logic [3:0] cwl, input logic [1:0] al);
        @(posedge clk);
        mode_burst <= m;
        cas_wr_lat <= cwl;
        add_lat_sel <= al;
        @(negedge ck);
    endtask
    task automatic wr_go(input logic [12:0] a, input int wl, input int drv, input int n);
        logic [9:0] c;
        u_ctrl.issue(1'b1, a);
        fork
            u_ctrl.wr_data(wl, a[9:0], drv);
        join_none
        for (int k = 0; k < n; k++) begin
            c = {a[9:3], a[2:0] + k[2:0]};
            exp_q.push_back({c, u_ctrl.dat(c)});
            wr_mask[c[5:0]] = 1'b1;
        end
    endtask
    // sampled mid-beat: outputs lag the pin edge by a few clk
    task automatic rd_chk(input logic [9:0] col, input int rl, input int n,
                          input bit pre, input bit post);
        logic [9:0] c;
        #((rl - 1) * 400 + 100);
        if (pre)
            chk({dqs_oe, dqs_o, dq_oe}, 3'h4);
        #400;
        for (int k = 0; k < n; k++) begin
            c = {col[9:3], col[2:0] + k[2:0]};
            chk({dq_oe, dqs_o, dq_o}, {1'b1, ~k[0], wr_mask[c[5:0]] ? u_ctrl.dat(c) : 8'h00});
            #200;
        end
        if (post) begin
            chk({dqs_oe, dqs_o, dq_oe}, 3'h4);
            #200;
            chk(dqs_oe, 1'b0);
        end
    endtask
    task automatic rd_go(input logic [12:0] a, input int rl, input int n,
                         input bit pre, input bit post);
        u_ctrl.issue(1'b0, a);
        fork
            rd_chk(a[9:0], rl, n, pre, post);
        join_none
    endtask
    task automatic wq_chk();
        chk(seen_q.size(), exp_q.size());
        while (seen_q.size() > 0 && exp_q.size() > 0)
            chk(seen_q.pop_front(), exp_q.pop_front());
        chk(wbeat_valid, 1'b0);
        seen_q.delete();
        exp_q.delete();
    endtask
    // hang guard, well past the expected run
    initial begin
        #200000;
        err_total++;
        final_report();
    end
    initial begin
        rst_n = 1'b0;
        mode_burst = 2'h1;
        cas_lat = 4'h5;
        cas_wr_lat = 4'h5;
        add_lat_sel = 2'h0;
        wbeat_ready = 1'b1;
        wr_mask = '0;
        err_total = 0;
        tests_run = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk({dq_oe, dqs_oe, wbeat_valid, wbuf_ready}, 4'h1);
        @(negedge ck);
        wr_go(13'h1008, 5, 10, 8);
        gap(12);
        wr_go(13'h1018, 5, 8, 8);
        gap(4);
        wr_go(13'h0426, 5, 4, 4);
        gap(12);
        wq_chk();
        cfg(2'h3, 4'h6, 2'h0);
        wr_go(13'h0030, 6, 8, 8);
        gap(14);
        wq_chk();
        cfg(2'h2, 4'h5, 2'h0);
        wr_go(13'h1038, 5, 8, 4);
        gap(10);
        wq_chk();
        $display("test writes done");
        // stalled receiver: two beats fit, the rest are lost
        @(posedge clk);
        wbeat_ready <= 1'b0;
        @(negedge ck);
        wr_go(13'h003c, 5, 4, 2);
        gap(9);
        chk(wbuf_ready, 1'b0);
        @(posedge clk);
        wbeat_ready <= 1'b1;
        repeat (4) @(negedge clk);
        wq_chk();
        $display("test buffer done");
        cfg(2'h0, 4'h5, 2'h1);
        wr_go(13'h1000, 9, 8, 8);
        gap(16);
        wq_chk();
        rd_go(13'h0000, 9, 8, 1, 1);
        gap(16);
        $display("test additive done");
        cfg(2'h0, 4'h5, 2'h0);
        rd_go(13'h0008, 5, 8, 1, 0);
        gap(4);
        rd_go(13'h000c, 5, 8, 0, 0);
        gap(5);
        rd_go(13'h0030, 5, 8, 1, 1);
        gap(12);
        cfg(2'h1, 4'h5, 2'h0);
        rd_go(13'h1018, 5, 8, 1, 0);
        gap(4);
        rd_go(13'h0426, 5, 4, 0, 1);
        gap(4);
        wr_go(13'h0010, 5, 4, 4);
        gap(10);
        rd_go(13'h1008, 5, 8, 1, 1);
        gap(6);
        wr_go(13'h1008, 5, 8, 8);
        gap(12);
        wq_chk();
        cfg(2'h2, 4'h5, 2'h0);
        rd_go(13'h0026, 5, 4, 1, 1);
        gap(5);
        rd_go(13'h103c, 5, 4, 1, 1);
        gap(10);
        $display("test reads done");
        final_report();
    end
endmodule // tb_top
